// file: verilog/ptmr_pkg.sv
// Constants shared by the periodic timer control register block
`default_nettype none
package ptmr_pkg;
    localparam int          CNT_W       = 10;
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 8;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [3:0]  OFS_CTRL0   = 4'h0;
    localparam logic [3:0]  OFS_CTRL1   = 4'h1;
    localparam logic [3:0]  OFS_CNT_L   = 4'h2;
    localparam logic [3:0]  OFS_CNT_H   = 4'h3;
    localparam logic [3:0]  OFS_CMPA_L  = 4'h4;
    localparam logic [3:0]  OFS_CMPA_H  = 4'h5;
    localparam logic [3:0]  OFS_CMPP_L  = 4'h6;
    localparam logic [3:0]  OFS_CMPP_H  = 4'h7;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int          CTRL0_ON    = 3;
    localparam int          MODE_HI     = 7;
    localparam int          MODE_LO     = 6;
    localparam int          PINF_HI     = 5;
    localparam int          PINF_LO     = 4;
    localparam int          LVL_BIT     = 3;
    localparam int          INV_BIT     = 2;
    localparam int          CLR_BIT     = 0;
    // --------------------------------------------------------------
    // Reset values and counter top value
    // --------------------------------------------------------------
    localparam logic [7:0]  CTRL1_RST   = 8'h00;
    localparam logic [9:0]  CNT_RST     = 10'h000;
    localparam logic [9:0]  CMP_RST     = 10'h000;
    localparam logic [9:0]  CNT_MAX     = 10'h3FF;
    localparam logic [7:0]  RD_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        MODE_CMP   = 2'b00,
        MODE_UNDEF = 2'b01,
        MODE_PWM   = 2'b10,
        MODE_TMR   = 2'b11
    } ptmr_mode_t;

    localparam logic [1:0]  PF_00       = 2'b00;
    localparam logic [1:0]  PF_01       = 2'b01;
    localparam logic [1:0]  PF_10       = 2'b10;
    localparam logic [1:0]  PF_11       = 2'b11;
endpackage
`default_nettype wire

// file: verilog/ptmr_regs.sv
// Periodic timer: control, counter and compare registers with pin logic
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Mode field picks compare, PWM/pulse, timer.
// - Timer mode: pin unused, undefined.
// - Compare-A match: hold, low, high, toggle.
// - PWM: inactive, active, waveform, single pulse.
// - Requested level equal initial: no change.
// - Counter-on rise restores initial pin level.
// - Compare mode: level bit sets initial.
// - PWM: level bit sets active polarity.
// - Single pulse: level bit on start.
// - Invert bit inverts pin, not timer mode.
// - Clear source: A match or P match.
// - Overflow clear only when compare-P zero.
// - Clear source ignored in PWM, pulse.
// - Counter readable only, split low/high.
// - Compare-A read/write byte pair.
// - Compare-P read/write byte pair.
// - High byte bits 7..2 read zero.
// - On rise clears counter; fall holds.
// - PWM period from P, duty from A.
// - Single pulse A match clears on.
module ptmr_regs
    import ptmr_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   timer_output_pin,
    output logic                   timer_output_pin_oe,
    output logic                   match_a_evt,
    output logic                   match_p_evt
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] hi_byte(input logic [9:0] v);
        hi_byte = {6'h00, v[9:8]};
    endfunction

    logic [7:0]   ctrl1_ff;
    logic         on_ff;
    logic [9:0]   cnt_ff;
    logic [9:0]   nxt_cnt;
    logic [9:0]   cmpa_ff;
    logic [9:0]   cmpp_ff;
    logic         lvl_ff;
    logic         pin_ff;
    logic         oe_ff;
    logic         nxt_pin;
    logic         mtc_a_ff;
    logic         mtc_p_ff;
    logic [7:0]   rdata_ff;
    logic [7:0]   rd_mux;

    ptmr_mode_t   mode;
    logic [1:0]   pinf;
    logic         oc;
    logic         inv;
    logic         clr_src;
    logic         wr_ctrl0;
    logic         on_rise;
    logic         cmp_like;
    logic         single;
    logic         pwm_act;
    logic         match_a;
    logic         match_p;
    logic         cnt_clr;

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    // mode decode
    assign mode     = ptmr_mode_t'(ctrl1_ff[MODE_HI:MODE_LO]);
    assign pinf     = ctrl1_ff[PINF_HI:PINF_LO];
    assign oc       = ctrl1_ff[LVL_BIT];
    assign inv      = ctrl1_ff[INV_BIT];
    assign clr_src  = ctrl1_ff[CLR_BIT];
    assign wr_ctrl0 = reg_wr && (reg_addr == OFS_CTRL0);
    // Undefined mode behaves like the timer mode: pin released
    assign cmp_like = (mode == MODE_CMP) || (mode == MODE_TMR)
                   || (mode == MODE_UNDEF);
    assign single   = (mode == MODE_PWM) && (pinf == PF_11);
    assign on_rise  = wr_ctrl0 && reg_wdata[CTRL0_ON] && !on_ff;

    // ------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------
    // Compare-A of zero never matches in compare modes
    always_comb begin
        match_a = 1'b0;
        match_p = 1'b0;
        if (on_ff) begin
            if (cmp_like) begin
                match_a = (cnt_ff == cmpa_ff) && (cmpa_ff != CMP_RST);
                match_p = !clr_src && (cmpp_ff != CMP_RST)
                       && (cnt_ff == cmpp_ff);
            end else begin
                match_a = (cnt_ff == cmpa_ff);
                match_p = !single
                       && (cnt_ff == 10'(cmpp_ff - 10'h001));
            end
        end
    end

    // ------------------------------------------------------------------
    // Counter clear and next value
    // ------------------------------------------------------------------
    always_comb begin
        cnt_clr = 1'b0;
        if (cmp_like) begin
            // overflow wraps when compare-P is zero
            cnt_clr = clr_src ? match_a : match_p;
        end else if (!single) begin
            // clear source ignored, counter clears at P-1 (period of P counts)
            cnt_clr = match_p;
        end
        nxt_cnt = cnt_ff;
        if (on_rise) begin
            nxt_cnt = CNT_RST;
        end else if (on_ff && cnt_clr) begin
            nxt_cnt = CNT_RST;
        end else if (on_ff) begin
            nxt_cnt = 10'(cnt_ff + 10'h001);
        end
    end

    // counter cleared on rise, held when off
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_ff <= CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Counter-on control
    // ------------------------------------------------------------------
    // Software write wins over the automatic stop in the same cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            on_ff <= 1'b0;
        end else if (wr_ctrl0) begin
            on_ff <= reg_wdata[CTRL0_ON];
        end else if (single && match_a) begin
            on_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    // Reserved bit 1 is stored as written; keeping it zero is up to code
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl1_ff <= CTRL1_RST;
        end else if (reg_wr && (reg_addr == OFS_CTRL1)) begin
            ctrl1_ff <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmpa_ff <= CMP_RST;
        end else if (reg_wr && (reg_addr == OFS_CMPA_L)) begin
            cmpa_ff[7:0] <= reg_wdata;
        end else if (reg_wr && (reg_addr == OFS_CMPA_H)) begin
            cmpa_ff[9:8] <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmpp_ff <= CMP_RST;
        end else if (reg_wr && (reg_addr == OFS_CMPP_L)) begin
            cmpp_ff[7:0] <= reg_wdata;
        end else if (reg_wr && (reg_addr == OFS_CMPP_H)) begin
            cmpp_ff[9:8] <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = RD_ZERO;
        unique case (reg_addr)
            OFS_CTRL0:  rd_mux = 8'(on_ff) << CTRL0_ON;
            OFS_CTRL1:  rd_mux = ctrl1_ff;
            OFS_CNT_L:  rd_mux = cnt_ff[7:0];
            // upper bits of high bytes read zero
            OFS_CNT_H:  rd_mux = hi_byte(cnt_ff);
            OFS_CMPA_L: rd_mux = cmpa_ff[7:0];
            OFS_CMPA_H: rd_mux = hi_byte(cmpa_ff);
            OFS_CMPP_L: rd_mux = cmpp_ff[7:0];
            OFS_CMPP_H: rd_mux = hi_byte(cmpp_ff);
            default:    rd_mux = RD_ZERO;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_ff <= RD_ZERO;
        end else if (reg_rd) begin
            rdata_ff <= rd_mux;
        end else begin
            rdata_ff <= RD_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Pin level state
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lvl_ff <= 1'b0;
        end else if (on_rise) begin
            lvl_ff <= oc;
        // equal levels give no visible change
        end else if (mode == MODE_CMP && match_a) begin
            unique case (pinf)
                PF_00: lvl_ff <= lvl_ff;
                PF_01: lvl_ff <= 1'b0;
                PF_10: lvl_ff <= 1'b1;
                PF_11: lvl_ff <= !lvl_ff;
            endcase
        end
    end

    // duty from compare-A, full when A reaches period
    assign pwm_act = (cnt_ff < cmpa_ff)
                  || ((cmpp_ff != CMP_RST) && (cmpa_ff >= cmpp_ff));

    always_comb begin
        nxt_pin = lvl_ff;
        if (mode == MODE_PWM) begin
            unique case (pinf)
                PF_00: nxt_pin = !oc;
                PF_01: nxt_pin = oc;
                PF_10: nxt_pin = pwm_act ? oc : !oc;
                PF_11: nxt_pin = on_ff ? oc : !oc;
            endcase
        end
    end

    // Pin is registered: it follows its cause by one cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else if (!(mode == MODE_CMP || mode == MODE_PWM)) begin
            pin_ff <= 1'b0;
            oe_ff  <= 1'b0;
        end else begin
            pin_ff <= nxt_pin ^ inv;
            oe_ff  <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mtc_a_ff <= 1'b0;
            mtc_p_ff <= 1'b0;
        end else begin
            mtc_a_ff <= match_a;
            mtc_p_ff <= match_p;
        end
    end

    assign reg_rdata           = rdata_ff;
    assign timer_output_pin    = pin_ff;
    assign timer_output_pin_oe = oe_ff;
    assign match_a_evt         = mtc_a_ff;
    assign match_p_evt         = mtc_p_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_start;
        wr_ctrl0 && reg_wdata[CTRL0_ON] && !on_ff;
    endsequence

    sequence s_idle;
        !on_ff && !wr_ctrl0;
    endsequence

    property p_start_clears;
        @(posedge ref_clk) disable iff (rst)
        s_start |=> (cnt_ff == CNT_RST) && on_ff && (lvl_ff == $past(oc));
    endproperty
    a_start_clears: assert property (p_start_clears)
        else $error("start did not clear counter");

    property p_off_holds;
        @(posedge ref_clk) disable iff (rst)
        s_idle ##1 s_idle |=> $stable(cnt_ff);
    endproperty
    a_off_holds: assert property (p_off_holds)
        else $error("counter moved while off");

    property p_toggle;
        @(posedge ref_clk) disable iff (rst)
        (mode == MODE_CMP && match_a && pinf == PF_11 && !on_rise)
        |=> lvl_ff != $past(lvl_ff);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle on compare-A missing");

    property p_force_inactive;
        @(posedge ref_clk) disable iff (rst)
        (mode == MODE_PWM && pinf == PF_00)
        |=> pin_ff == (!$past(oc) ^ $past(inv));
    endproperty
    a_force_inactive: assert property (p_force_inactive)
        else $error("forced inactive level wrong");

    property p_clr_a;
        @(posedge ref_clk) disable iff (rst)
        (mode == MODE_CMP && clr_src && match_a && !wr_ctrl0)
        |=> cnt_ff == CNT_RST;
    endproperty
    a_clr_a: assert property (p_clr_a)
        else $error("compare-A clear missing");

    property p_overflow;
        @(posedge ref_clk) disable iff (rst)
        (mode == MODE_CMP && on_ff && !clr_src && cmpp_ff == CMP_RST
         && cnt_ff == CNT_MAX && !wr_ctrl0) |=> cnt_ff == CNT_RST;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow did not wrap");

    property p_pulse_stop;
        @(posedge ref_clk) disable iff (rst)
        (single && match_a && !wr_ctrl0) |=> !on_ff
            ##1 pin_ff == (!$past(oc) ^ $past(inv));
    endproperty
    a_pulse_stop: assert property (p_pulse_stop)
        else $error("pulse did not end on compare-A");

    property p_high_zero;
        @(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr[0] && reg_addr != OFS_CTRL1)
        |=> reg_rdata[7:2] == 6'h00;
    endproperty
    a_high_zero: assert property (p_high_zero)
        else $error("high byte upper bits not zero");

    property p_timer_off;
        @(posedge ref_clk) disable iff (rst)
        (mode == MODE_TMR) |=> !timer_output_pin_oe;
    endproperty
    a_timer_off: assert property (p_timer_off)
        else $error("pin driven in timer mode");
endmodule // ptmr_regs
`default_nettype wire

// file: test/ptmr_regs_tb.sv
// Self-checking bench for the periodic timer register block
`timescale 1ns/1ps
`default_nettype none
module ptmr_regs_tb
    import ptmr_pkg::*;
;
    logic              ref_clk = 1'b0;
    logic              rst     = 1'b1;
    logic [ADDR_W-1:0] reg_addr  = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              pin, pin_oe, ev_a, ev_p;
    int                fails = 0;
    int                check_count = 0;
    int                cycles = 0;
    int                n, h;
    logic [7:0]        d, d2;
    // Per-row register write then readback
    // reserved control bit 1 kept zero
    logic [3:0] t_addr [10] = '{4'h1, 4'h1, 4'h4, 4'h5, 4'h6,
                                4'h7, 4'h2, 4'h3, 4'h9, 4'h0};
    logic [7:0] t_wdat [10] = '{8'hFD, 8'h00, 8'hA5, 8'hFF, 8'h5A,
                                8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'h07};
    logic [7:0] t_exp  [10] = '{8'hFD, 8'h00, 8'hA5, 8'h03, 8'h5A,
                                8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

    ptmr_regs ptmr_regs_inst (
        .ref_clk             (ref_clk),
        .rst                 (rst),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .timer_output_pin    (pin),
        .timer_output_pin_oe (pin_oe),
        .match_a_evt         (ev_a),
        .match_p_evt         (ev_p)
    );

    always #2 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard, generous against the few thousand cycles expected
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask

    // Cycles until the chosen event pulses, bounded
    task automatic wait_ev(input bit sel_p, output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            #1 k = k + 1;
        end while (((sel_p ? ev_p : ev_a) !== 1'b1) && k < 2000);
    endtask

    task automatic cnt_hi(input int k, output int hi);
        hi = 0;
        repeat (k) begin
            @(posedge ref_clk);
            #1 if (pin === 1'b1) hi = hi + 1;
        end
    endtask

    // Timer stopped before mode or pin function change
    task automatic cfg(input logic [7:0] c1, input logic [9:0] a,
                       input logic [9:0] p);
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL1, c1 & 8'hFD);
        wr(OFS_CMPA_L, a[7:0]);
        wr(OFS_CMPA_H, {6'h00, a[9:8]});
        wr(OFS_CMPP_L, p[7:0]);
        wr(OFS_CMPP_H, {6'h00, p[9:8]});
        wr(OFS_CTRL0, 8'h08);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(i[3:0], d);
            chk(d, 8'h00);
        end
        for (int i = 0; i < 10; i++) begin
            wr(t_addr[i], t_wdat[i]);
            rd(t_addr[i], d);
            chk(d, t_exp[i]);
        end
        $display("register table done");
        // Compare mode, drive high on A match, clear on A
        cfg(8'h21, 10'h005, 10'h000);
        cyc(2);
        chk(pin, 1'b0);
        chk(pin_oe, 1'b1);
        wait_ev(1'b0, n);
        chk(n >= 4 && n <= 7, 1'b1);
        cyc(2);
        chk(pin, 1'b1);
        wr(OFS_CTRL0, 8'h00);
        wr(OFS_CTRL0, 8'h08);
        cyc(2);
        chk(pin, 1'b0);
        // Requested level equals initial level
        cfg(8'h11, 10'h005, 10'h000);
        wait_ev(1'b0, n);
        cnt_hi(6, h);
        chk(h, 0);
        // Initial high, driven low on match; then no-change code
        cfg(8'h19, 10'h005, 10'h000);
        cyc(2);
        chk(pin, 1'b1);
        wait_ev(1'b0, n);
        cyc(2);
        chk(pin, 1'b0);
        cfg(8'h09, 10'h005, 10'h000);
        wait_ev(1'b0, n);
        cnt_hi(6, h);
        chk(h, 6);
        // Inverted output
        cfg(8'h25, 10'h005, 10'h000);
        cyc(2);
        chk(pin, 1'b1);
        wait_ev(1'b0, n);
        cyc(2);
        chk(pin, 1'b0);
        // Toggle on each match
        cfg(8'h31, 10'h003, 10'h000);
        wait_ev(1'b0, n);
        wait_ev(1'b0, n);
        chk(n, 4);
        chk(pin, 1'b1);
        cyc(2);
        chk(pin, 1'b0);
        // Clear on P match with A below P
        cfg(8'h20, 10'h003, 10'h006);
        wait_ev(1'b1, n);
        wait_ev(1'b1, n);
        chk(n, 7);
        // Compare-P zero: counter wraps after its top value
        cfg(8'h20, 10'h005, 10'h000);
        wait_ev(1'b0, n);
        wait_ev(1'b0, n);
        chk(n, 1024);
        $display("compare mode done");
        // PWM period 8 duty 2, both polarities, full duty
        cfg(8'hA8, 10'h002, 10'h008);
        cyc(20);
        cnt_hi(16, h);
        chk(h, 4);
        wait_ev(1'b1, n);
        wait_ev(1'b1, n);
        chk(n, 8);
        cfg(8'hA0, 10'h002, 10'h008);
        cyc(20);
        cnt_hi(16, h);
        chk(h, 12);
        cfg(8'hA8, 10'h009, 10'h008);
        cyc(20);
        cnt_hi(16, h);
        chk(h, 16);
        cfg(8'hA9, 10'h002, 10'h008);
        wait_ev(1'b1, n);
        wait_ev(1'b1, n);
        chk(n, 8);
        cfg(8'h88, 10'h002, 10'h008);
        cyc(4);
        cnt_hi(16, h);
        chk(h, 0);
        cfg(8'h98, 10'h002, 10'h008);
        cyc(4);
        cnt_hi(16, h);
        chk(h, 16);
        $display("pwm done");
        // Single pulse ends itself on A match
        cfg(8'hB8, 10'h004, 10'h000);
        cyc(2);
        chk(pin, 1'b1);
        wait_ev(1'b0, n);
        cyc(3);
        chk(pin, 1'b0);
        rd(OFS_CTRL0, d);
        chk(d, 8'h00);
        $display("single pulse done");
        // Timer mode, pin released; stop holds the count
        cfg(8'hE0, 10'h000, 10'h200);
        cyc(2);
        chk(pin_oe, 1'b0);
        cyc(300);
        wr(OFS_CTRL0, 8'h00);
        rd(OFS_CNT_H, d2);
        rd(OFS_CNT_L, d);
        chk({d2[1:0], d} >= 10'd290 && {d2[1:0], d} <= 10'd320, 1'b1);
        chk(d2[7:2], 6'h00);
        rd(OFS_CNT_L, d2);
        chk(d2, d);
        cyc(1);
        chk(reg_rdata, 8'h00);
        wr(OFS_CTRL0, 8'h08);
        rd(OFS_CNT_H, d2);
        rd(OFS_CNT_L, d);
        chk(d2 === 8'h00 && d < 8'h08, 1'b1);
        $display("counter done");
        // Mid-run reset with the pin driven
        cfg(8'h21, 10'h005, 10'h000);
        @(posedge ref_clk);
        rst <= 1'b1;
        cyc(2);
        chk({pin_oe, pin}, 2'b00);
        @(posedge ref_clk);
        rst <= 1'b0;
        rd(OFS_CTRL1, d);
        rd(OFS_CNT_L, d2);
        chk({d, d2}, 16'h0000);
        $display("reset done");
        finish_test();
    end
endmodule // ptmr_regs_tb
`default_nettype wire
